// ===== eq_recovery_page_pkg.sv
/*
 * Constants for the equalizer / recovery register page: offsets, field
 * positions of its bit fields, and reset values and write masks of its stored cells.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package eq_recovery_page_pkg;

  // page decode against the shared page register
  localparam logic [1:0] PAGE_CODE = 2'b00;

  // offsets
  localparam logic [7:0] ADDR_PAGE_RESET = 8'h00;
  localparam logic [7:0] ADDR_SIGNAL_LOSS = 8'h01;
  localparam logic [7:0] ADDR_RECOVERY_STATUS = 8'h02;
  localparam logic [7:0] ADDR_MANUAL_BOOST = 8'h03;
  localparam logic [7:0] ADDR_SPARE_4 = 8'h04;
  localparam logic [7:0] ADDR_SPARE_5 = 8'h05;
  localparam logic [7:0] ADDR_SPARE_6 = 8'h06;
  localparam logic [7:0] ADDR_SPARE_7 = 8'h07;
  localparam logic [7:0] ADDR_SPARE_8 = 8'h08;
  localparam logic [7:0] ADDR_OUTPUT_OVERRIDE = 8'h09;
  localparam logic [7:0] ADDR_STATUS_VIEW = 8'h0c;
  localparam logic [7:0] ADDR_FIRST_OUTPUT_SEL = 8'h1c;
  localparam logic [7:0] ADDR_SECOND_OUTPUT_SEL = 8'h1e;
  localparam logic [7:0] ADDR_MANUAL_EQ_CTRL = 8'h2d;
  localparam logic [7:0] ADDR_EFFECTIVE_BOOST = 8'h52;

  // reset values
  localparam logic [7:0] RST_PAGE_RESET = 8'h00;
  localparam logic [7:0] RST_SIGNAL_LOSS = 8'h03;
  localparam logic [7:0] RST_RECOVERY_STATUS = 8'h41;
  localparam logic [7:0] RST_MANUAL_BOOST = 8'h80;
  localparam logic [7:0] RST_SPARE = 8'h00;
  localparam logic [7:0] RST_OUTPUT_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_STATUS_VIEW = 8'h08;
  localparam logic [7:0] RST_FIRST_OUTPUT_SEL = 8'h00;
  localparam logic [7:0] RST_SECOND_OUTPUT_SEL = 8'h00;
  localparam logic [7:0] RST_MANUAL_EQ_CTRL = 8'h00;

  // write masks: bits software may store
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_PAGE_RESET = 8'hfb;
  localparam logic [7:0] MASK_SIGNAL_LOSS = 8'hfc;

  // field positions
  localparam int PAGE_RESET_BIT = 2;
  localparam int LOSS_BIT = 1;
  localparam int LOSS_RSVD_BIT = 0;
  localparam int OVERRIDE_BIT = 5;
  localparam int MANUAL_EQ_BIT = 3;
  localparam int VIEW_LSB = 4;
  localparam int VIEW_W = 4;
  localparam int SHARED_SEL_LSB = 2;
  localparam int SHARED_SEL_W = 2;
  localparam int OWN_SEL_LSB = 5;
  localparam int SEL_W = 3;
  localparam int BOOST_W = 2;
  localparam int STAGE0_LSB = 6;
  localparam int STAGE1_LSB = 4;
  localparam int STAGE2_LSB = 2;
  localparam int STAGE3_LSB = 0;

  // stored byte cells
  localparam int NUM_CELLS = 14;
  localparam logic [7:0] CELL_ADDR [NUM_CELLS] = '{
    ADDR_PAGE_RESET, ADDR_SIGNAL_LOSS, ADDR_MANUAL_BOOST, ADDR_SPARE_4,
    ADDR_SPARE_5, ADDR_SPARE_6, ADDR_SPARE_7, ADDR_SPARE_8,
    ADDR_OUTPUT_OVERRIDE, ADDR_STATUS_VIEW, ADDR_FIRST_OUTPUT_SEL,
    ADDR_SECOND_OUTPUT_SEL, ADDR_MANUAL_EQ_CTRL, ADDR_RECOVERY_STATUS};
  localparam logic [7:0] CELL_RST [NUM_CELLS] = '{
    RST_PAGE_RESET, RST_SIGNAL_LOSS, RST_MANUAL_BOOST, RST_SPARE,
    RST_SPARE, RST_SPARE, RST_SPARE, RST_SPARE,
    RST_OUTPUT_OVERRIDE, RST_STATUS_VIEW, RST_FIRST_OUTPUT_SEL,
    RST_SECOND_OUTPUT_SEL, RST_MANUAL_EQ_CTRL, RST_RECOVERY_STATUS};
  localparam logic [7:0] CELL_MASK [NUM_CELLS] = '{
    MASK_PAGE_RESET, MASK_SIGNAL_LOSS, MASK_ALL, MASK_ALL,
    MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL,
    MASK_ALL, MASK_ALL, MASK_ALL,
    MASK_ALL, MASK_ALL, 8'h00};

  // cell indices used by the logic
  localparam int CI_PAGE_RESET = 0;
  localparam int CI_SIGNAL_LOSS = 1;
  localparam int CI_MANUAL_BOOST = 2;
  localparam int CI_OUTPUT_OVERRIDE = 8;
  localparam int CI_STATUS_VIEW = 9;
  localparam int CI_FIRST_OUTPUT_SEL = 10;
  localparam int CI_SECOND_OUTPUT_SEL = 11;
  localparam int CI_MANUAL_EQ_CTRL = 12;
  localparam int CI_RECOVERY_STATUS = 13;

endpackage : eq_recovery_page_pkg

// ===== page_byte_cell.sv
/*
 * One stored byte of the register page with its own reset value and a
 * mask of the bits software may write.
 * Assumes the page reset pulse and write strobe are synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module page_byte_cell #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic pageReset,
  input wire logic writeEnable,
  input wire logic [7:0] writeData,
  // stored value
  output logic [7:0] value
);

  logic [7:0] next_value;

  // masked bits keep their value, so read-only reserved bits ignore writes
  assign next_value = (value & ~WRITE_MASK) | (writeData & WRITE_MASK); // R12

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      value <= RESET_VALUE;
    end else if (pageReset) begin
      value <= RESET_VALUE; // R1
    end else if (writeEnable) begin
      value <= next_value;
    end
  end

endmodule : page_byte_cell

`default_nettype wire

// ===== equalizer_recovery_page_regs.sv
/*
 * Register page for the secondary-input equalizer and clock/data recovery:
 * page reset, signal-loss status, recovery status view, manual boost with
 * its effective readback, and output source selection.
 * Assumes a serial control port front end that presents byte accesses as
 * one-cycle strobes synchronous to core_clk, and a shared page register
 * outside this block that supplies the page-select enable and code.
 */
// What this block does
// R1 - writing page reset bit restores defaults, self-clears
// R2 - software re-initializes registers after a page reset
// R3 - loss bit reads 1 without secondary input signal
// R4 - read-only recovery status byte, default 0x41
// R5 - manual boost applies only while manual enable set
// R6 - boost byte holds four 2-bit stage fields
// R7 - effective boost readable at offset 0x52
// R8 - override clear: shared field steers both outputs
// R9 - override set: each output has own field
// R10 - page decoded only when enabled with code 00
// R11 - status view field picks recovery status items
// R12 - reserved bits store writes, read-only ones ignore
`timescale 1ns/1ps
`default_nettype none

module equalizer_recovery_page_regs
  import eq_recovery_page_pkg::*;
#(
  parameter int NUM_VIEWS = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // shared page register fields
  input wire logic pageSelectEnable,
  input wire logic [1:0] pageSelect,
  // byte register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  // analog and recovery status
  input wire logic secondaryInputSignalDetect,
  input wire logic [NUM_VIEWS*8-1:0] recoveryStatusItems,
  input wire logic [7:0] adaptiveBoost,
  // equalizer control
  output logic manualEqActive,
  output logic [BOOST_W-1:0] stage0Boost,
  output logic [BOOST_W-1:0] stage1Boost,
  output logic [BOOST_W-1:0] stage2Boost,
  output logic [BOOST_W-1:0] stage3Boost,
  // output mux control
  output logic [SEL_W-1:0] firstOutputSelect,
  output logic [SEL_W-1:0] secondOutputSelect,
  // page reset in progress
  output logic pageResetPulse
);

  logic pageOn;
  logic [NUM_CELLS-1:0] cellHit;
  logic [7:0] cellValue [NUM_CELLS];
  logic [7:0] cellRead [NUM_CELLS];
  logic [7:0] cellReadOr;
  logic [7:0] cellWriteData [NUM_CELLS];
  logic [NUM_CELLS-1:0] cellWrite;
  logic hitLoss;
  logic hitEffective;
  logic secondaryInputSignalLoss;
  logic [VIEW_W-1:0] statusViewSelect;
  logic [7:0] selectedStatus;
  logic manualEnable;
  logic [7:0] manualBoost;
  logic [7:0] effectiveBoost;
  logic [7:0] next_effectiveBoost;
  logic outputSelectOverride;
  logic [SEL_W-1:0] sharedSelect;
  logic [SEL_W-1:0] next_firstSelect;
  logic [SEL_W-1:0] next_secondSelect;
  logic next_pageReset;
  logic [7:0] lossByte;
  logic [7:0] pageResetByte;
  logic [7:0] next_readData;

  function automatic logic addrIs(input logic [7:0] a, input logic [7:0] target);
    addrIs = (a == target);
  endfunction : addrIs

  // accesses only reach this page while it is the selected one
  assign pageOn = pageSelectEnable && (pageSelect == PAGE_CODE); // R10

  generate
    for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
      assign cellHit[i] = pageOn && addrIs(regAddr, CELL_ADDR[i]); // R10
      assign cellWrite[i] = regWrite && cellHit[i];
      page_byte_cell #(
        .RESET_VALUE(CELL_RST[i]),
        .WRITE_MASK(CELL_MASK[i])
      ) u_cell (
        .core_clk(core_clk),
        .rst(rst),
        .pageReset(pageResetPulse),
        .writeEnable(cellWrite[i] || (i == CI_RECOVERY_STATUS)),
        .writeData(cellWriteData[i]),
        .value(cellValue[i])
      );
      assign cellRead[i] = cellHit[i] ? cellValue[i] : 8'h00;
    end
  endgenerate

  // the recovery status cell is never writable by software; its zero mask
  // also blocks the selected view, so it holds its reset value
  generate
    for (genvar j = 0; j < NUM_CELLS; j++) begin : g_wdata
      if (j == CI_RECOVERY_STATUS) begin : g_status
        assign cellWriteData[j] = selectedStatus;
      end else begin : g_sw
        assign cellWriteData[j] = regWriteData;
      end
    end
  endgenerate

  always_comb begin
    cellReadOr = 8'h00;
    for (int k = 0; k < NUM_CELLS; k++) begin
      cellReadOr = cellReadOr | cellRead[k];
    end
  end

  // recovery status: view field chooses which items are reported
  assign statusViewSelect = cellValue[CI_STATUS_VIEW][VIEW_LSB +: VIEW_W]; // R11
  assign selectedStatus = recoveryStatusItems[statusViewSelect * 8 +: 8]; // R4 R11

  // status cell has a zero write mask, so feed it through a mask-free path
  logic [7:0] recoveryStatus;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      recoveryStatus <= RST_RECOVERY_STATUS; // R4
    end else if (pageResetPulse) begin
      recoveryStatus <= RST_RECOVERY_STATUS;
    end else begin
      recoveryStatus <= selectedStatus; // R4
    end
  end

  // signal loss: bit 1 live, bit 0 reserved read-only, 7:2 stored
  logic lossFlag;
  assign secondaryInputSignalLoss = !secondaryInputSignalDetect; // R3
  assign lossByte = {cellValue[CI_SIGNAL_LOSS][7:2], lossFlag,
                     RST_SIGNAL_LOSS[LOSS_RSVD_BIT]}; // R12
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lossFlag <= RST_SIGNAL_LOSS[LOSS_BIT];
    end else begin
      lossFlag <= secondaryInputSignalLoss; // R3
    end
  end

  // page reset bit reads 1 only for the cycle the reset is applied
  assign pageResetByte = cellValue[CI_PAGE_RESET] |
                         ({7'h00, pageResetPulse} << PAGE_RESET_BIT);
  assign next_pageReset = cellWrite[CI_PAGE_RESET] &&
                          regWriteData[PAGE_RESET_BIT]; // R1

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pageResetPulse <= 1'b0;
    end else begin
      pageResetPulse <= next_pageReset; // R1
    end
  end

  // manual boost: four 2-bit stage fields, applied only when enabled
  assign manualEnable = cellValue[CI_MANUAL_EQ_CTRL][MANUAL_EQ_BIT]; // R5
  assign manualBoost = cellValue[CI_MANUAL_BOOST];
  assign next_effectiveBoost = manualEnable ? manualBoost : adaptiveBoost; // R5

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      effectiveBoost <= RST_MANUAL_BOOST;
      manualEqActive <= 1'b0;
    end else begin
      effectiveBoost <= next_effectiveBoost; // R5
      manualEqActive <= manualEnable;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage0Boost <= RST_MANUAL_BOOST[STAGE0_LSB +: BOOST_W];
      stage1Boost <= RST_MANUAL_BOOST[STAGE1_LSB +: BOOST_W];
      stage2Boost <= RST_MANUAL_BOOST[STAGE2_LSB +: BOOST_W];
      stage3Boost <= RST_MANUAL_BOOST[STAGE3_LSB +: BOOST_W];
    end else begin
      stage0Boost <= next_effectiveBoost[STAGE0_LSB +: BOOST_W]; // R6
      stage1Boost <= next_effectiveBoost[STAGE1_LSB +: BOOST_W]; // R6
      stage2Boost <= next_effectiveBoost[STAGE2_LSB +: BOOST_W]; // R6
      stage3Boost <= next_effectiveBoost[STAGE3_LSB +: BOOST_W]; // R6
    end
  end

  // output source selection
  assign outputSelectOverride = cellValue[CI_OUTPUT_OVERRIDE][OVERRIDE_BIT];
  assign sharedSelect = {1'b0,
    cellValue[CI_FIRST_OUTPUT_SEL][SHARED_SEL_LSB +: SHARED_SEL_W]}; // R8
  assign next_firstSelect = outputSelectOverride ?
    cellValue[CI_FIRST_OUTPUT_SEL][OWN_SEL_LSB +: SEL_W] : sharedSelect; // R8 R9
  assign next_secondSelect = outputSelectOverride ?
    cellValue[CI_SECOND_OUTPUT_SEL][OWN_SEL_LSB +: SEL_W] : sharedSelect; // R8 R9

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      firstOutputSelect <= '0;
      secondOutputSelect <= '0;
    end else begin
      firstOutputSelect <= next_firstSelect;
      secondOutputSelect <= next_secondSelect;
    end
  end

  // read path: special bytes first, then stored cells, else zero
  assign hitLoss = pageOn && addrIs(regAddr, ADDR_SIGNAL_LOSS);
  assign hitEffective = pageOn && addrIs(regAddr, ADDR_EFFECTIVE_BOOST);
  logic hitStatus;
  logic hitPageReset;
  assign hitStatus = pageOn && addrIs(regAddr, ADDR_RECOVERY_STATUS);
  assign hitPageReset = pageOn && addrIs(regAddr, ADDR_PAGE_RESET);

  always_comb begin
    if (hitLoss) begin
      next_readData = lossByte; // R3
    end else if (hitStatus) begin
      next_readData = recoveryStatus; // R4
    end else if (hitEffective) begin
      next_readData = effectiveBoost; // R7
    end else if (hitPageReset) begin
      next_readData = pageResetByte; // R1
    end else begin
      next_readData = cellReadOr;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      regReadData <= next_readData;
    end
  end

endmodule : equalizer_recovery_page_regs

`default_nettype wire

// ===== eq_page_regs_checker_sva.sv
/*
 * Port-level checker for the equalizer / recovery register page.
 * Assumes it is bound to the page module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module eq_page_regs_checker
  import eq_recovery_page_pkg::*;
#(
  parameter int NUM_VIEWS = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic pageSelectEnable,
  input wire logic [1:0] pageSelect,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  // status inputs
  input wire logic secondaryInputSignalDetect,
  input wire logic [NUM_VIEWS*8-1:0] recoveryStatusItems,
  input wire logic [7:0] adaptiveBoost,
  // controls
  input wire logic manualEqActive,
  input wire logic [BOOST_W-1:0] stage0Boost,
  input wire logic [BOOST_W-1:0] stage1Boost,
  input wire logic [BOOST_W-1:0] stage2Boost,
  input wire logic [BOOST_W-1:0] stage3Boost,
  input wire logic [SEL_W-1:0] firstOutputSelect,
  input wire logic [SEL_W-1:0] secondOutputSelect,
  input wire logic pageResetPulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  localparam logic [39:0] SH_RST = {RST_MANUAL_BOOST, RST_OUTPUT_OVERRIDE,
    RST_FIRST_OUTPUT_SEL, RST_SECOND_OUTPUT_SEL, RST_MANUAL_EQ_CTRL};
  // shadows rebuilt from observed writes, so outputs can be predicted
  logic pageOn;
  logic [7:0] shBoost, shOver, shFirst, shSecond, shManual, expBoost;
  logic [SEL_W-1:0] expFirst, expSecond;
  logic [7:0] stages;
  assign pageOn = pageSelectEnable && pageSelect == PAGE_CODE;
  assign stages = {stage0Boost, stage1Boost, stage2Boost, stage3Boost};
  assign expBoost = shManual[MANUAL_EQ_BIT] ? shBoost : adaptiveBoost;
  assign expFirst = shOver[OVERRIDE_BIT] ? shFirst[7:5] : {1'b0, shFirst[3:2]};
  assign expSecond = shOver[OVERRIDE_BIT] ? shSecond[7:5] : {1'b0, shFirst[3:2]};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst || pageResetPulse) begin
      {shBoost, shOver, shFirst, shSecond, shManual} <= SH_RST;
    end else if (regWrite && pageOn) begin
      if (regAddr == ADDR_MANUAL_BOOST) shBoost <= regWriteData;
      if (regAddr == ADDR_OUTPUT_OVERRIDE) shOver <= regWriteData;
      if (regAddr == ADDR_FIRST_OUTPUT_SEL) shFirst <= regWriteData;
      if (regAddr == ADDR_SECOND_OUTPUT_SEL) shSecond <= regWriteData;
      if (regAddr == ADDR_MANUAL_EQ_CTRL) shManual <= regWriteData;
    end
  end
  sequence s_reset_req;
    regWrite && pageOn && !pageResetPulse && regAddr == ADDR_PAGE_RESET
      && regWriteData[PAGE_RESET_BIT];
  endsequence
  sequence s_reset_pulse;
    pageResetPulse ##1 !pageResetPulse;
  endsequence
  // the cycle after a reset of either kind is skipped: outputs reload there
  sequence s_steady;
    !$past(rst) && !$past(pageResetPulse);
  endsequence
  property p_reset_pulse;
    s_reset_req |=> s_reset_pulse;
  endproperty
  property p_reset_defaults;
    pageResetPulse |-> ##2 !manualEqActive;
  endproperty
  property p_loss_read;
    regRead && pageOn && regAddr == ADDR_SIGNAL_LOSS && $stable(secondaryInputSignalDetect)
      && !$past(rst) && !pageResetPulse && !$past(pageResetPulse)
      |=> regReadData[1:0] == {!$past(secondaryInputSignalDetect), 1'b1};
  endproperty
  property p_boost_eff;
    s_steady |-> stages == $past(expBoost);
  endproperty
  property p_manual_flag;
    s_steady |-> manualEqActive == $past(shManual[MANUAL_EQ_BIT]);
  endproperty
  property p_boost_readback;
    regRead && pageOn && regAddr == ADDR_EFFECTIVE_BOOST |=> regReadData == $past(stages);
  endproperty
  property p_first_sel;
    s_steady |-> firstOutputSelect == $past(expFirst);
  endproperty
  property p_second_sel;
    s_steady |-> secondOutputSelect == $past(expSecond);
  endproperty
  property p_unselected_read;
    regRead && !pageOn |=> regReadData == 8'h00;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("page reset write gave no single pulse");
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("manual enable survived page reset");
  a_loss_read: assert property (p_loss_read)
    else $error("loss bit does not follow signal detect");
  a_boost_eff: assert property (p_boost_eff)
    else $error("stage boosts differ from selected boost source");
  a_manual_flag: assert property (p_manual_flag)
    else $error("manual enable output differs from written bit");
  a_boost_readback: assert property (p_boost_readback)
    else $error("effective boost readback differs from stages");
  a_first_sel: assert property (p_first_sel)
    else $error("first output select wrong");
  a_second_sel: assert property (p_second_sel)
    else $error("second output select wrong");
  a_unselected_read: assert property (p_unselected_read)
    else $error("read without page selection returned data");
endmodule : eq_page_regs_checker
`default_nettype wire

// ===== equalizer_recovery_page_regs_tb.sv
/*
 * Self-checking bench for the equalizer / recovery register page.
 * Assumes the design package and the checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module equalizer_recovery_page_regs_tb
  import eq_recovery_page_pkg::*;
;
  logic core_clk = 0;
  logic rst = 1;
  logic pageSelectEnable = 1;
  logic [1:0] pageSelect = 2'b00;
  logic regWrite = 0;
  logic regRead = 0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic secondaryInputSignalDetect = 0;
  logic [127:0] recoveryStatusItems;
  logic [7:0] adaptiveBoost = 8'h1b;
  logic [7:0] regReadData;
  logic manualEqActive, pageResetPulse;
  logic [1:0] stage0Boost, stage1Boost, stage2Boost, stage3Boost;
  logic [2:0] firstOutputSelect, secondOutputSelect;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] defAddr [14] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h09, 8'h0c, 8'h1c, 8'h1e, 8'h2d, 8'h52};
  logic [7:0] defVal [14] = '{8'h00, 8'h03, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h1b};

  equalizer_recovery_page_regs u_dut (.core_clk(core_clk), .rst(rst),
    .pageSelectEnable(pageSelectEnable), .pageSelect(pageSelect), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
    .regReadData(regReadData), .secondaryInputSignalDetect(secondaryInputSignalDetect),
    .recoveryStatusItems(recoveryStatusItems), .adaptiveBoost(adaptiveBoost),
    .manualEqActive(manualEqActive), .stage0Boost(stage0Boost), .stage1Boost(stage1Boost),
    .stage2Boost(stage2Boost), .stage3Boost(stage3Boost),
    .firstOutputSelect(firstOutputSelect), .secondOutputSelect(secondOutputSelect),
    .pageResetPulse(pageResetPulse));

  always #4 core_clk = ~core_clk;

  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      $display("ERROR run length expected below 2000 seen 2000");
      finish_test();
    end
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    regAddr = a;
    regWriteData = d;
    regWrite = 1;
    @(posedge core_clk);
    #1;
    regWrite = 0;
  endtask : wr

  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task check_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1;
    regAddr = a;
    regRead = 1;
    @(posedge core_clk);
    #1;
    regRead = 0;
    check($sformatf("reg %h", a), exp, regReadData);
  endtask : check_reg

  // outputs lag the write edge by one cycle
  task settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle

  initial begin
    for (int v = 0; v < 16; v++) recoveryStatusItems[8*v +: 8] = 8'h40 + 8'(v);
    repeat (8) @(posedge core_clk);
    #1;
    rst = 0;
    for (int i = 0; i < 14; i++) check_reg(defAddr[i], defVal[i]);
    check_reg(ADDR_RECOVERY_STATUS, 8'h40);
    $display("defaults test done");
    wr(ADDR_STATUS_VIEW, 8'h5a);
    wr(ADDR_RECOVERY_STATUS, 8'hff);
    check_reg(ADDR_RECOVERY_STATUS, 8'h45);
    for (int i = 4; i < 9; i++) begin
      wr(8'(i), 8'ha0 + 8'(i));
      check_reg(8'(i), 8'ha0 + 8'(i));
    end
    wr(ADDR_SIGNAL_LOSS, 8'ha8);
    check_reg(ADDR_SIGNAL_LOSS, 8'hab);
    secondaryInputSignalDetect = 1;
    settle();
    check_reg(ADDR_SIGNAL_LOSS, 8'ha9);
    secondaryInputSignalDetect = 0;
    $display("status test done");
    wr(ADDR_FIRST_OUTPUT_SEL, 8'he8);
    wr(ADDR_SECOND_OUTPUT_SEL, 8'h60);
    settle();
    check("firstSel", 8'h02, {5'h0, firstOutputSelect});
    check("secondSel", 8'h02, {5'h0, secondOutputSelect});
    wr(ADDR_OUTPUT_OVERRIDE, 8'h20);
    settle();
    check("firstSel", 8'h07, {5'h0, firstOutputSelect});
    check("secondSel", 8'h03, {5'h0, secondOutputSelect});
    $display("select test done");
    wr(ADDR_MANUAL_BOOST, 8'he4);
    settle();
    check("stages", 8'h1b, {stage0Boost, stage1Boost, stage2Boost, stage3Boost});
    wr(ADDR_MANUAL_EQ_CTRL, 8'h08);
    settle();
    check("stages", 8'he4, {stage0Boost, stage1Boost, stage2Boost, stage3Boost});
    check("manualEq", 8'h01, {7'h0, manualEqActive});
    wr(ADDR_EFFECTIVE_BOOST, 8'h00);
    check_reg(ADDR_EFFECTIVE_BOOST, 8'he4);
    $display("boost test done");
    wr(ADDR_PAGE_RESET, 8'h04);
    settle();
    for (int i = 0; i < 14; i++) check_reg(defAddr[i], defVal[i]);
    check("firstSel", 8'h00, {5'h0, firstOutputSelect});
    wr(ADDR_MANUAL_EQ_CTRL, 8'h08);
    settle();
    check("stages", 8'h80, {stage0Boost, stage1Boost, stage2Boost, stage3Boost});
    $display("page reset test done");
    // a nonzero stored byte, so an unselected read or write would show
    wr(ADDR_SPARE_4, 8'h3c);
    pageSelectEnable = 0;
    wr(ADDR_SPARE_4, 8'h77);
    check_reg(ADDR_SPARE_4, 8'h00);
    pageSelectEnable = 1;
    pageSelect = 2'b01;
    wr(ADDR_SPARE_4, 8'h55);
    check_reg(ADDR_SPARE_4, 8'h00);
    pageSelect = 2'b00;
    check_reg(ADDR_SPARE_4, 8'h3c);
    $display("page select test done");
    finish_test();
  end
endmodule : equalizer_recovery_page_regs_tb

bind equalizer_recovery_page_regs eq_page_regs_checker #(.NUM_VIEWS(NUM_VIEWS)) u_chk (
  .core_clk(core_clk), .rst(rst), .pageSelectEnable(pageSelectEnable),
  .pageSelect(pageSelect), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regWriteData(regWriteData), .regReadData(regReadData),
  .secondaryInputSignalDetect(secondaryInputSignalDetect),
  .recoveryStatusItems(recoveryStatusItems), .adaptiveBoost(adaptiveBoost),
  .manualEqActive(manualEqActive), .stage0Boost(stage0Boost), .stage1Boost(stage1Boost),
  .stage2Boost(stage2Boost), .stage3Boost(stage3Boost),
  .firstOutputSelect(firstOutputSelect), .secondOutputSelect(secondOutputSelect),
  .pageResetPulse(pageResetPulse));
`default_nettype wire
